/* hw/hcts_defines.vh */
// constants for the half-channel trigger sequencer
`ifndef HCTS_DEFINES_VH
`define HCTS_DEFINES_VH
// register offsets (byte addresses)
`define HCTS_A_CTRL 8'h00
`define HCTS_A_STATUS 8'h04
`define HCTS_A_CMP0 8'h10
`define HCTS_A_CMP5 8'h24
`define HCTS_A_LVL0 8'h30
`define HCTS_A_LVL1 8'h34
`define HCTS_A_STORE 8'h38
`define HCTS_A_TRIGPOS 8'h3C
`define HCTS_A_RDADDR 8'h40
`define HCTS_A_RDDATA 8'h44
`define HCTS_A_WRPTR 8'h48
// control fields
`define HCTS_F_FN_LO 0
`define HCTS_F_START 2
`define HCTS_F_STOP 3
`define HCTS_F_ARMCFG 4
`define HCTS_F_SQEN 5
`define HCTS_CTRL_RST 6'h00
// trigger functions
`define HCTS_FN_FIND 2'h0
`define HCTS_FN_IMM 2'h1
`define HCTS_FN_EVT 2'h2
`define HCTS_FN_RUN 2'h3
// comparator config fields
`define HCTS_C_OP_LO 8
`define HCTS_C_SPLIT 11
`define HCTS_C_REORD 12
`define HCTS_C_EN 13
`define HCTS_CMP_RST 14'h0000
// comparator operations
`define HCTS_OP_EQ 3'h0
`define HCTS_OP_NE 3'h1
`define HCTS_OP_LT 3'h2
`define HCTS_OP_LE 3'h3
`define HCTS_OP_GT 3'h4
`define HCTS_OP_GE 3'h5
`define HCTS_OP_IN 3'h6
`define HCTS_OP_OUT 3'h7
// level config fields
`define HCTS_L_OR 6
`define HCTS_L_FM_LO 7
`define HCTS_L_FP_LO 11
`define HCTS_L_ARM 15
`define HCTS_LVL_RST 16'h0000
// sizes
`define HCTS_NPOD 2
`define HCTS_NSLOT 3
`define HCTS_DW 16
`define HCTS_AW 27
`define HCTS_ADDR_MAX 27'h7FFFFFF
`define HCTS_MAX_SIDE 3'h3
`endif

/* hw/hcts_trace_mem.v */
// trace memory: one write port, registered read port
module hcts_trace_mem (
  input wire clk, // system clock
  input wire we, // write enable
  input wire [26:0] waddr, // write address
  input wire [15:0] wdata, // write data
  input wire [26:0] raddr, // read address
  output reg [15:0] rdata // registered read data
);
  reg [15:0] mem [0:134217727];

  // write and read each clock; read data lag the address by one cycle
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

/* hw/hcts_sequencer.v */
// half-channel trigger sequencer with store qualification
`include "hcts_defines.vh"
module hcts_sequencer (
  input wire sys_clk, // system clock, 100 MHz
  input wire rstn, // asynchronous reset, active low
  input wire [7:0] bus_addr, // register byte address
  input wire [31:0] bus_wdata, // register write data
  input wire bus_wr, // write strobe
  input wire bus_rd, // read strobe
  output reg [31:0] bus_rdata, // read data, cycle after strobe
  input wire tgt_clk, // target sampling clock from the pod
  input wire [31:0] pod_data, // raw channels, 16 per pod
  input wire [3:0] xflag, // shared flags from other modules
  input wire cross_module_arm_event, // arm from bus or external
  output reg running, // acquisition in progress
  output reg triggered, // trigger point reached
  output reg mem_full // trace memory filled
);
  localparam ST_IDLE = 3'h0;
  localparam ST_L0 = 3'h1;
  localparam ST_L1 = 3'h2;
  localparam ST_POST = 3'h3;
  localparam ST_DONE = 3'h4;

  ////////////////////////////////////////////////////////////////////
  // input synchronisers
  reg [2:0] tclk_q; // two sync stages plus edge history
  reg [15:0] dat_s1_q, dat_s2_q;
  reg [3:0] flg_s1_q, flg_s2_q;
  reg arm_s1_q, arm_s2_q;
  wire [15:0] even_ch;
  genvar gi;

  // only even channels enter; odd channels and pod clock bits dropped
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_even
      assign even_ch[gi] = pod_data[2*gi];
      assign even_ch[8+gi] = pod_data[16+2*gi];
    end
  endgenerate

  // every pod, flag and arm pin passes two flops before any logic looks at it; bus pins go straight in
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tclk_q <= 3'h0;
      dat_s1_q <= 16'h0000;
      dat_s2_q <= 16'h0000;
      flg_s1_q <= 4'h0;
      flg_s2_q <= 4'h0;
      arm_s1_q <= 1'b0;
      arm_s2_q <= 1'b0;
    end else begin
      tclk_q <= {tclk_q[1:0], tgt_clk};
      dat_s1_q <= even_ch;
      dat_s2_q <= dat_s1_q;
      flg_s1_q <= xflag;
      flg_s2_q <= flg_s1_q;
      arm_s1_q <= cross_module_arm_event;
      arm_s2_q <= arm_s1_q;
    end
  end

  // a sample is taken on each rising edge of the target clock
  wire samp_stb = tclk_q[1] & ~tclk_q[2];

  ////////////////////////////////////////////////////////////////////
  // configuration registers
  reg [1:0] fn_q;
  reg armcfg_q, sqen_q;
  reg [13:0] cmp_q [0:5];
  reg [15:0] lvl0_q, lvl1_q;
  reg [5:0] store_q;
  reg [26:0] rdaddr_q;
  reg cfg_err_q;
  reg [2:0] st_q;
  reg [26:0] wptr_q, trig_q;
  wire start_req = bus_wr & (bus_addr == `HCTS_A_CTRL)
    & bus_wdata[`HCTS_F_START];
  wire stop_req = bus_wr & (bus_addr == `HCTS_A_CTRL)
    & bus_wdata[`HCTS_F_STOP];
  integer k;

  // settings except the read address are frozen while running so the compare stays consistent
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fn_q <= `HCTS_FN_FIND;
      armcfg_q <= 1'b0;
      sqen_q <= 1'b0;
      lvl0_q <= `HCTS_LVL_RST;
      lvl1_q <= `HCTS_LVL_RST;
      store_q <= 6'h00;
      rdaddr_q <= 27'h0000000;
      for (k = 0; k < 6; k = k + 1) begin
        cmp_q[k] <= `HCTS_CMP_RST;
      end
    end else if (bus_wr) begin
      if (bus_addr == `HCTS_A_RDADDR) begin
        rdaddr_q <= bus_wdata[26:0];
      end
      if (!running) begin
        case (bus_addr)
          `HCTS_A_CTRL: begin
            fn_q <= bus_wdata[1:0];
            armcfg_q <= bus_wdata[`HCTS_F_ARMCFG];
            sqen_q <= bus_wdata[`HCTS_F_SQEN];
          end
          `HCTS_A_LVL0: lvl0_q <= bus_wdata[15:0];
          `HCTS_A_LVL1: lvl1_q <= bus_wdata[15:0];
          `HCTS_A_STORE: store_q <= bus_wdata[5:0];
          default: begin
            if (bus_addr >= `HCTS_A_CMP0 && bus_addr <= `HCTS_A_CMP5
                && bus_addr[1:0] == 2'h0) begin
              cmp_q[bus_addr[4:2] - 3'h4] <= bus_wdata[13:0];
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // comparators: three slots per pod, slot s of pod 1 is index s+3
  wire [5:0] raw_hit;
  wire [5:0] hit;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_cmp
      wire [7:0] v = dat_s2_q[(gi/3)*8 +: 8];
      wire [7:0] ref_v = cmp_q[gi][7:0];
      wire [2:0] op = cmp_q[gi][10:8];
      // range borrows the next slot of the pod as its upper bound; the pod's last slot uses its own value
      wire [7:0] hi = cmp_q[(gi % 3 == 2) ? gi : gi + 1][7:0];
      wire inr = (v >= ref_v) && (v <= hi);
      // split pairs both pods' slots as one 16-bit equality test
      wire [15:0] sref = {cmp_q[(gi%3)+3][7:0], cmp_q[gi%3][7:0]};
      wire seq = (dat_s2_q == sref);
      wire eqonly = cmp_q[gi%3][`HCTS_C_SPLIT] | cmp_q[gi][`HCTS_C_REORD];
      reg h;
      always @* begin
        h = 1'b0;
        if (cmp_q[gi%3][`HCTS_C_SPLIT]) begin
          h = (op == `HCTS_OP_NE) ? ~seq : seq;
        end else if (eqonly) begin
          h = (op == `HCTS_OP_NE) ? (v != ref_v) : (v == ref_v);
        end else begin
          case (op)
            `HCTS_OP_EQ: h = (v == ref_v);
            `HCTS_OP_NE: h = (v != ref_v);
            `HCTS_OP_LT: h = (v < ref_v);
            `HCTS_OP_LE: h = (v <= ref_v);
            `HCTS_OP_GT: h = (v > ref_v);
            `HCTS_OP_GE: h = (v >= ref_v);
            `HCTS_OP_IN: h = inr;
            `HCTS_OP_OUT: h = ~inr;
            default: h = 1'b0;
          endcase
        end
      end
      assign raw_hit[gi] = h & cmp_q[gi][`HCTS_C_EN];
    end
  endgenerate

  // a slot eaten as a range bound or by a split in pod 0 gives no hit
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_use
      wire prev_rng = (gi % 3 != 0) && !cmp_q[gi-((gi%3!=0)?1:0)]
        [`HCTS_C_SPLIT] && (cmp_q[gi-((gi%3!=0)?1:0)][10:9] == 2'h3);
      wire split_eat = (gi >= 3) && cmp_q[gi%3][`HCTS_C_SPLIT];
      assign hit[gi] = raw_hit[gi] & ~prev_rng & ~split_eat;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // level evaluation and configuration check
  function lvl_match;
    input [15:0] c;
    input [5:0] h;
    input [3:0] f;
    input a;
    reg pat, flg, arm;
    begin
      if (c[5:0] == 6'h00) begin
        pat = 1'b1;
      end else if (c[`HCTS_L_OR]) begin
        pat = |(c[5:0] & h);
      end else begin
        pat = &(~c[5:0] | h);
      end
      flg = &(~c[10:7] | ~(f ^ c[14:11]));
      arm = ~c[`HCTS_L_ARM] | a;
      lvl_match = pat & flg & arm;
    end
  endfunction

  // extra terms on a level: flags plus arm
  function [2:0] side_cnt;
    input [15:0] c;
    begin
      side_cnt = {2'h0, c[7]} + {2'h0, c[8]} + {2'h0, c[9]}
        + {2'h0, c[10]} + {2'h0, c[15]};
    end
  endfunction

  // eventual levels: at most one pattern, and none on a split label
  function evt_bad;
    input [15:0] c;
    reg [2:0] n;
    reg sp;
    begin
      n = {2'h0, c[0]} + {2'h0, c[1]} + {2'h0, c[2]} + {2'h0, c[3]}
        + {2'h0, c[4]} + {2'h0, c[5]};
      sp = (c[0] | c[3]) & cmp_q[0][`HCTS_C_SPLIT]
        | (c[1] | c[4]) & cmp_q[1][`HCTS_C_SPLIT]
        | (c[2] | c[5]) & cmp_q[2][`HCTS_C_SPLIT];
      evt_bad = (n > 3'h1) | sp;
    end
  endfunction

  wire arm_ok = arm_s2_q & armcfg_q;
  wire m0 = lvl_match(lvl0_q, hit, flg_s2_q, arm_ok);
  wire m1 = lvl_match(lvl1_q, hit, flg_s2_q, arm_ok);
  wire cfg_bad = (side_cnt(lvl0_q) > `HCTS_MAX_SIDE)
    | (side_cnt(lvl1_q) > `HCTS_MAX_SIDE)
    | ((fn_q == `HCTS_FN_EVT)
       & (evt_bad(lvl0_q) | evt_bad(lvl1_q)));
  // qualifier draws on the same six comparator hits
  wire qual = ~sqen_q | |(store_q & hit);

  ////////////////////////////////////////////////////////////////////
  // sequencer
  reg [2:0] st_d;
  reg trig_now;
  always @* begin
    st_d = st_q;
    trig_now = 1'b0;
    case (st_q)
      ST_L0: begin
        if (fn_q == `HCTS_FN_RUN) begin
          st_d = ST_L0;
        end else if (m0) begin
          if (fn_q == `HCTS_FN_FIND) begin
            trig_now = 1'b1;
          end else begin
            st_d = ST_L1;
          end
        end
      end
      ST_L1: begin
        if (m1) begin
          trig_now = 1'b1;
        end else if (fn_q == `HCTS_FN_IMM) begin
          st_d = m0 ? ST_L1 : ST_L0;
        end else begin
          st_d = ST_L1;
        end
      end
      default: st_d = st_q;
    endcase
    if (trig_now) begin
      st_d = ST_POST;
    end
  end

  wire in_acq = (st_q == ST_L0) | (st_q == ST_L1) | (st_q == ST_POST);
  wire do_store = in_acq & samp_stb & qual;
  wire [26:0] wptr_nx = wptr_q + 27'h0000001;
  // full when the next write would overwrite the trigger sample
  wire fill_end = (st_q == ST_POST) & do_store & (wptr_nx == trig_q);
  reg mem_we_q;
  reg [26:0] mem_wa_q;
  reg [15:0] mem_wd_q;

  // pre-trigger data wrap around; post-trigger data stop at full
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      wptr_q <= 27'h0000000;
      trig_q <= 27'h0000000;
      cfg_err_q <= 1'b0;
      running <= 1'b0;
      triggered <= 1'b0;
      mem_full <= 1'b0;
      mem_we_q <= 1'b0;
      mem_wa_q <= 27'h0000000;
      mem_wd_q <= 16'h0000;
    end else begin
      mem_we_q <= do_store;
      mem_wa_q <= wptr_q;
      mem_wd_q <= dat_s2_q;
      if (stop_req && in_acq) begin
        st_q <= ST_DONE;
        running <= 1'b0;
      end else if (start_req && !running) begin
        cfg_err_q <= cfg_bad;
        if (!cfg_bad) begin
          st_q <= ST_L0;
          running <= 1'b1;
          triggered <= 1'b0;
          mem_full <= 1'b0;
          wptr_q <= 27'h0000000;
        end
      end else if (samp_stb && in_acq) begin
        st_q <= st_d;
        if (do_store) begin
          wptr_q <= wptr_nx;
        end
        if (trig_now) begin
          trig_q <= wptr_q;
          triggered <= 1'b1;
        end
        if (fill_end) begin
          st_q <= ST_DONE;
          running <= 1'b0;
          mem_full <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trace memory
  wire [15:0] mem_rd;
  hcts_trace_mem u_mem (
    .clk(sys_clk),
    .we(mem_we_q),
    .waddr(mem_wa_q),
    .wdata(mem_wd_q),
    .raddr(rdaddr_q),
    .rdata(mem_rd)
  );

  ////////////////////////////////////////////////////////////////////
  // register read; unmapped addresses read zero
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    case (bus_addr)
      `HCTS_A_CTRL: rd_d = {26'h0, sqen_q, armcfg_q, 2'h0, fn_q};
      `HCTS_A_STATUS: rd_d = {24'h0, cfg_err_q, st_q, 1'b0, mem_full,
        triggered, running};
      `HCTS_A_LVL0: rd_d = {16'h0, lvl0_q};
      `HCTS_A_LVL1: rd_d = {16'h0, lvl1_q};
      `HCTS_A_STORE: rd_d = {26'h0, store_q};
      `HCTS_A_TRIGPOS: rd_d = {5'h0, trig_q};
      `HCTS_A_RDADDR: rd_d = {5'h0, rdaddr_q};
      `HCTS_A_RDDATA: rd_d = {16'h0, mem_rd};
      `HCTS_A_WRPTR: rd_d = {5'h0, wptr_q};
      default: begin
        if (bus_addr >= `HCTS_A_CMP0 && bus_addr <= `HCTS_A_CMP5
            && bus_addr[1:0] == 2'h0) begin
          rd_d = {18'h0, cmp_q[bus_addr[4:2] - 3'h4]};
        end
      end
    endcase
  end

  // read data valid only in the cycle after the strobe
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= 32'h00000000;
    end else begin
      bus_rdata <= bus_rd ? rd_d : 32'h00000000;
    end
  end
endmodule

/* sim/hcts_checker.sv */
// port checker for the half-channel trigger sequencer
`include "hcts_defines.vh"
module hcts_checker (
  input wire sys_clk, // system clock
  input wire rstn, // reset, active low
  input wire [7:0] bus_addr, // register address
  input wire [31:0] bus_wdata, // write data
  input wire bus_wr, // write strobe
  input wire bus_rd, // read strobe
  input wire [31:0] bus_rdata, // read data
  input wire tgt_clk, // target clock
  input wire [31:0] pod_data, // raw channels
  input wire [3:0] xflag, // shared flags
  input wire cross_module_arm_event, // arm input
  input wire running, // acquiring
  input wire triggered, // trigger reached
  input wire mem_full // memory filled
);
  reg tclk_q;
  reg [3:0] age_q;
  reg [1:0] fn_q;
  wire ctl_w = bus_wr && bus_addr == `HCTS_A_CTRL;
  wire start_w = ctl_w && bus_wdata[`HCTS_F_START];
  wire [3:0] age_d = (tgt_clk && !tclk_q) ? 4'h0 :
    (age_q == 4'hF) ? age_q : age_q + 4'h1;

  ////////////////////////////////////////
  // age of the last target edge saturates so it never wraps to look fresh
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tclk_q <= 1'h0;
      age_q <= 4'hF;
      fn_q <= `HCTS_FN_FIND;
    end else begin
      tclk_q <= tgt_clk;
      age_q <= age_d;
      if (ctl_w && !running) begin
        fn_q <= bus_wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_stop_req;
    ctl_w && bus_wdata[`HCTS_F_STOP];
  endsequence
  sequence s_halted;
    ##[1:2] !running;
  endsequence
  sequence s_run_req;
    start_w && bus_wdata[1:0] == `HCTS_FN_RUN && !running;
  endsequence
  // the trigger may only follow a synchronised target sample
  a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data outside a read answer");
  a_trig_sample: assert property ($rose(triggered) |-> age_q <= 4'h8)
    else $error("trigger without a recent target sample");
  a_trig_running: assert property ($rose(triggered) |-> $past(running))
    else $error("trigger outside an acquisition");
  a_trig_stands: assert property (
    triggered && !start_w && !$past(start_w) |=> triggered)
    else $error("trigger flag dropped without a start");
  a_full_idle: assert property ($rose(mem_full) |-> !running)
    else $error("still running with memory full");
  a_stop_ends: assert property (s_stop_req |-> s_halted)
    else $error("stop did not end the acquisition");
  a_run_starts: assert property (s_run_req |=> running)
    else $error("run mode did not start");
  a_run_untrig: assert property (
    fn_q == `HCTS_FN_RUN |-> !$rose(triggered))
    else $error("trigger seen in run mode");
endmodule
bind hcts_sequencer hcts_checker hcts_checker_inst (
  .sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .tgt_clk(tgt_clk), .pod_data(pod_data),
  .xflag(xflag), .cross_module_arm_event(cross_module_arm_event),
  .running(running), .triggered(triggered), .mem_full(mem_full)
);

/* sim/hcts_target_model.sv */
// probed target bus: sample clock and pod channels
module hcts_target_model (
  output logic tgt_clk, // sample clock, still between frames
  output logic [31:0] pod_data // channels, even bits carry data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tgt_clk = 1'h0;
    pod_data = 32'hFFFFFFFF;
  end
  // one 160 ns frame; odd channels carry the inverse so misuse shows
  task automatic send(input logic [15:0] s);
    integer i;
    for (i = 0; i < 16; i++) begin
      pod_data[2*i] = s[i];
      pod_data[2*i+1] = ~s[i];
    end
    #40 tgt_clk = 1'h1;
    #80 tgt_clk = 1'h0;
    #40 pod_data = ~pod_data;
  endtask
endmodule

/* sim/half_channel_trigger_sequencer_bench.sv */
// self-checking bench for the half-channel trigger sequencer
`include "hcts_defines.vh"
module half_channel_trigger_sequencer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk;
  logic rstn;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic [3:0] xflag;
  logic arm;
  wire [31:0] bus_rdata;
  wire tgt_clk;
  wire [31:0] pod_data;
  wire running;
  wire triggered;
  wire mem_full;
  integer n_errors = 0;
  integer check_count = 0;
  integer k;
  logic [31:0] v;
  logic [31:0] p;
  logic [7:0] hit = 8'h69; // eq, le, ge, in range hit at the value

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  hcts_sequencer hcts_sequencer_inst (
    .sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .tgt_clk(tgt_clk), .pod_data(pod_data),
    .xflag(xflag), .cross_module_arm_event(arm),
    .running(running), .triggered(triggered), .mem_full(mem_full)
  );
  hcts_target_model tgt (.tgt_clk(tgt_clk), .pod_data(pod_data));

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  // bus cycles: one-cycle strobes, read data taken in the next cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'h1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus_rd <= 1'h1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'h0;
    #1 d = bus_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  task automatic go(input logic [1:0] f, input logic [31:0] x);
    wr(`HCTS_A_CTRL, x | 32'h4 | {30'h0, f});
  endtask
  task automatic halt;
    wr(`HCTS_A_CTRL, 32'h8);
  endtask
  // a refused start leaves the error bit up and nothing running
  task automatic refuse(input logic [31:0] c, input logic [31:0] l,
      input logic [1:0] f);
    wr(`HCTS_A_CMP0, c);
    wr(`HCTS_A_LVL0, l);
    go(f, 32'h0);
    rd(`HCTS_A_STATUS, v);
    chk(v & 32'h81, 32'h80);
  endtask
  function automatic [31:0] st(input logic [2:0] s, input logic t);
    st = {25'h0, s, 2'h0, t, 1'h1};
  endfunction
  task automatic finish_test;
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    finish_test;
  end

  initial begin
    sys_clk = 1'h0;
    rstn = 1'h0;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    xflag = 4'h0;
    arm = 1'h0;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'h1;
    rc(`HCTS_A_CTRL, 32'h0);
    rc(`HCTS_A_STATUS, 32'h0);
    rc(`HCTS_A_LVL0, 32'h0);
    rc(8'h08, 32'h0);
    // each compare against a sample equal to its value
    wr(`HCTS_A_CMP0 + 8'h04, 32'h2048);
    wr(`HCTS_A_LVL0, 32'h1);
    for (k = 0; k < 8; k++) begin
      wr(`HCTS_A_CMP0, 32'h2028 | (k << 8));
      go(`HCTS_FN_FIND, 32'h0);
      tgt.send(16'h0028);
      chk(triggered, hit[k]);
      if (k == 0) begin
        rc(`HCTS_A_STATUS, st(3'h3, 1'h1));
      end
      halt;
      chk(triggered, hit[k]);
    end
    // a miss sends immediate back to the first level, eventual holds on
    wr(`HCTS_A_CMP0, 32'h2011);
    wr(`HCTS_A_CMP0 + 8'h04, 32'h2022);
    wr(`HCTS_A_LVL1, 32'h2);
    for (k = 1; k < 3; k++) begin
      go(k[1:0], 32'h0);
      tgt.send(16'h0011);
      tgt.send(16'h0033);
      rc(`HCTS_A_STATUS, st(k[2:0], 1'h0));
      tgt.send(16'h0022);
      chk(triggered, k == 2);
      tgt.send(16'h0011);
      tgt.send(16'h0022);
      chk(triggered, 1'h1);
      halt;
    end
    refuse(32'h2011, 32'h3, `HCTS_FN_EVT);
    refuse(32'h2811, 32'h1, `HCTS_FN_EVT);
    refuse(32'h2011, 32'h8781, `HCTS_FN_FIND);
    // flag set and the arm input both gate the trigger
    wr(`HCTS_A_LVL0, 32'h8880);
    go(`HCTS_FN_FIND, 32'h10);
    @(posedge sys_clk);
    xflag <= 4'h1;
    tgt.send(16'h0);
    chk(triggered, 1'h0);
    @(posedge sys_clk);
    arm <= 1'h1;
    tgt.send(16'h0);
    chk(triggered, 1'h1);
    halt;
    // run mode keeps only qualifying samples and ignores config writes
    wr(`HCTS_A_LVL0, 32'h0);
    wr(`HCTS_A_CMP0 + 8'h08, 32'h2077);
    wr(`HCTS_A_STORE, 32'h4);
    go(`HCTS_FN_RUN, 32'h20);
    rd(`HCTS_A_WRPTR, p);
    wr(`HCTS_A_CMP0, 32'h0);
    rc(`HCTS_A_CMP0, 32'h2011);
    tgt.send(16'h0077);
    tgt.send(16'h0010);
    tgt.send(16'h0077);
    rc(`HCTS_A_WRPTR, (p + 32'h2) & 32'h7FFFFFF);
    rd(`HCTS_A_STATUS, v);
    chk(v & 32'h3, 32'h1);
    halt;
    wr(`HCTS_A_RDADDR, p);
    chk(running, 1'h0);
    @(posedge sys_clk);
    rc(`HCTS_A_RDDATA, 32'h77);
    finish_test;
  end
endmodule
